//--- wdit_cfg.svh
// Purpose: offsets, field positions, reset values and counts for the timer
// Assumes: included by its bare name from the prescaler and top design files, not from the package
// Notes:   definitions only
`ifndef WDIT_CFG_SVH
`define WDIT_CFG_SVH

`define WDIT_ADDR_MODE        16'hFFF9
`define WDIT_ADDR_TBSEL       16'hFF42
`define WDIT_MODE_RESET       8'h00
`define WDIT_TBSEL_RESET      8'h00
`define WDIT_MODE_RUN_BIT     7
`define WDIT_MODE_WDSEL_BIT   4
`define WDIT_MODE_ACTION_BIT  3
`define WDIT_MODE_USED_MASK   8'h98
`define WDIT_TBSEL_USED_MASK  8'hF7
`define WDIT_TBSEL_FIELD_LSB  0
`define WDIT_TBSEL_FIELD_W    3
`define WDIT_PRE_W            11
`define WDIT_CNT_W            8
`define WDIT_CNT_LAST         8'hFF

`endif

//--- wdit_pkg.sv
// Purpose: shared types of the watchdog / interval timer
// Assumes: wdit_cfg.svh supplies the numeric constants
// Notes:   types only
package wdit_pkg;

  // overflow action, one-hot
  typedef enum logic [2:0] {
    WDIT_ACT_INTERVAL = 3'b001,
    WDIT_ACT_NMI      = 3'b010,
    WDIT_ACT_RESET    = 3'b100
  } wdit_action_e;

  typedef logic [2:0] wdit_tbsel_t;

endpackage : wdit_pkg

//--- wdit_prescaler.sv
// Purpose: free-running divider of the main clock and count-clock tap select
// Assumes: clk is the oscillator clock
// Notes:   never cleared by a restart, so first period may run short
`timescale 1ns/1ps
`include "wdit_cfg.svh"

module wdit_prescaler (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic                 main_clock_halving_sel,
  input  wire logic                 osc_stopped,
  input  wire wdit_pkg::wdit_tbsel_t tbsel,
  output logic                      count_tick
);

  logic                    half_r;
  logic                    fxx_en;
  logic [`WDIT_PRE_W-1:0]  pre_r;

  // low-bit mask for divide by 2^3 .. 2^9, then 2^11
  function automatic logic [`WDIT_PRE_W-1:0] tap_mask(input wdit_pkg::wdit_tbsel_t s);
    logic [`WDIT_PRE_W-1:0] m;
    m = 11'h007;
    case (s)
      3'd0: m = 11'h007;
      3'd1: m = 11'h00F;
      3'd2: m = 11'h01F;
      3'd3: m = 11'h03F;
      3'd4: m = 11'h07F;
      3'd5: m = 11'h0FF;
      3'd6: m = 11'h1FF;
      default: m = 11'h7FF;
    endcase
    return m;
  endfunction : tap_mask

  // fxx is fx when the select is one, fx/2 otherwise
  assign fxx_en = main_clock_halving_sel | half_r;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      half_r <= 1'b0;
    end else if (!osc_stopped) begin
      half_r <= ~half_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pre_r <= 11'h000;
    end else if (fxx_en && !osc_stopped) begin
      pre_r <= pre_r + 11'h001;
    end
  end

  assign count_tick = fxx_en && !osc_stopped &&
                      ((pre_r & tap_mask(tbsel)) == tap_mask(tbsel));

endmodule : wdit_prescaler

//--- wdit_top.sv
// Purpose: watchdog timer that may also run as an interval timer
// Assumes: cpu-side byte bus, one-cycle write strobe, read data a cycle later
// Notes:   pending flag kept here, cleared by the interrupt controller strobe
`timescale 1ns/1ps
`include "wdit_cfg.svh"

module wdit_top (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [7:0]  bus_wdata,
  output logic      [7:0]  bus_rdata_r,
  input  wire logic        main_clock_halving_sel,
  input  wire logic        halt_mode,
  input  wire logic        stop_mode,
  input  wire logic        cpu_on_subclock,
  input  wire logic        wd_irq_mask,
  input  wire logic        wd_irq_priority,
  input  wire logic        pending_clr,
  output logic             wd_pending_flag_r,
  output logic             interval_irq_r,
  output logic             interval_irq_prio_r,
  output logic             nmi_req_r,
  output logic             wdt_reset_req_r
);

  logic [7:0]                    mode_r;
  logic [7:0]                    tbsel_r;
  logic [`WDIT_CNT_W-1:0]        cnt_r;
  logic                          mode_wr;
  logic                          tbsel_wr;
  logic                          restart;
  logic                          count_tick;
  logic                          counting;
  logic                          overflow;
  logic                          wdsel_rise;
  wdit_pkg::wdit_action_e        action;

  assign mode_wr  = bus_wr && (bus_addr == `WDIT_ADDR_MODE);
  assign tbsel_wr = bus_wr && (bus_addr == `WDIT_ADDR_TBSEL);
  assign restart  = mode_wr && bus_wdata[`WDIT_MODE_RUN_BIT];
  assign wdsel_rise = mode_wr && bus_wdata[`WDIT_MODE_WDSEL_BIT] &&
                      !mode_r[`WDIT_MODE_WDSEL_BIT];

  // bits only ever set by software; clearing needs reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mode_r <= `WDIT_MODE_RESET;
    end else if (mode_wr) begin
      mode_r <= mode_r | (bus_wdata & `WDIT_MODE_USED_MASK);
    end
  end

  // changing it while running is a software error, not guarded here
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tbsel_r <= `WDIT_TBSEL_RESET;
    end else if (tbsel_wr) begin
      tbsel_r <= bus_wdata & `WDIT_TBSEL_USED_MASK;
    end
  end

  always_comb begin
    if (!mode_r[`WDIT_MODE_WDSEL_BIT]) begin
      action = wdit_pkg::WDIT_ACT_INTERVAL;
    end else if (!mode_r[`WDIT_MODE_ACTION_BIT]) begin
      action = wdit_pkg::WDIT_ACT_NMI;
    end else begin
      action = wdit_pkg::WDIT_ACT_RESET;
    end
  end

  // halt_mode deliberately not used: counting carries on in halt
  assign counting = mode_r[`WDIT_MODE_RUN_BIT] && !stop_mode &&
                    !cpu_on_subclock && !(halt_mode && 1'b0);

  wdit_prescaler u_pre (
    .clk                    (clk),
    .resetn                 (resetn),
    .main_clock_halving_sel (main_clock_halving_sel),
    .osc_stopped            (stop_mode),
    .tbsel                  (tbsel_r[`WDIT_TBSEL_FIELD_LSB +: `WDIT_TBSEL_FIELD_W]),
    .count_tick             (count_tick)
  );

  assign overflow = counting && count_tick && !restart &&
                    (cnt_r == `WDIT_CNT_LAST);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_r <= 8'h00;
    end else if (restart) begin
      cnt_r <= 8'h00;
    end else if (counting && count_tick) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wd_pending_flag_r <= 1'b0;
    end else if (overflow && action == wdit_pkg::WDIT_ACT_INTERVAL) begin
      wd_pending_flag_r <= 1'b1;
    end else if (pending_clr) begin
      wd_pending_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      interval_irq_r <= 1'b0;
    end else begin
      interval_irq_r <= overflow && action == wdit_pkg::WDIT_ACT_INTERVAL &&
                        !wd_irq_mask;
    end
  end

  // default high priority unless the priority flag says low
  always_ff @(posedge clk) begin
    if (!resetn) begin
      interval_irq_prio_r <= 1'b0;
    end else begin
      interval_irq_prio_r <= wd_irq_priority;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      nmi_req_r <= 1'b0;
    end else begin
      nmi_req_r <= (overflow && action == wdit_pkg::WDIT_ACT_NMI) ||
                   (wdsel_rise && wd_pending_flag_r);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wdt_reset_req_r <= 1'b0;
    end else begin
      wdt_reset_req_r <= overflow && action == wdit_pkg::WDIT_ACT_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      bus_rdata_r <= 8'h00;
    end else if (bus_rd && bus_addr == `WDIT_ADDR_MODE) begin
      bus_rdata_r <= mode_r;
    end else if (bus_rd && bus_addr == `WDIT_ADDR_TBSEL) begin
      bus_rdata_r <= tbsel_r;
    end else begin
      bus_rdata_r <= 8'h00;
    end
  end

endmodule : wdit_top

//--- wdit_monitor.sv
// Purpose: port checks for the watchdog / interval timer
// Assumes: bound to wdit_top, one clock domain
// Notes:   periods are timed by the bench, too long for here
`timescale 1ns/1ps
module wdit_monitor (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [15:0] bus_addr,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [7:0]  bus_wdata,
  input wire logic [7:0]  bus_rdata_r,
  input wire logic        main_clock_halving_sel,
  input wire logic        halt_mode,
  input wire logic        stop_mode,
  input wire logic        cpu_on_subclock,
  input wire logic        wd_irq_mask,
  input wire logic        wd_irq_priority,
  input wire logic        pending_clr,
  input wire logic        wd_pending_flag_r,
  input wire logic        interval_irq_r,
  input wire logic        interval_irq_prio_r,
  input wire logic        nmi_req_r,
  input wire logic        wdt_reset_req_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_irq_pulse; interval_irq_r |=> !interval_irq_r; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq pulse too long");
  property p_nmi_pulse; nmi_req_r |=> !nmi_req_r; endproperty
  a_nmi_pulse: assert property (p_nmi_pulse) else $error("nmi pulse too long");
  property p_rst_pulse; wdt_reset_req_r |=> !wdt_reset_req_r; endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
  property p_one; $onehot0({interval_irq_r, nmi_req_r, wdt_reset_req_r}); endproperty
  a_one: assert property (p_one) else $error("two overflow actions at once");
  property p_mask; interval_irq_r |-> !$past(wd_irq_mask); endproperty
  a_mask: assert property (p_mask) else $error("masked irq seen");
  property p_prio; $past(resetn) |-> interval_irq_prio_r == $past(wd_irq_priority); endproperty
  a_prio: assert property (p_prio) else $error("priority copy wrong");
  property p_rd_idle; !$past(bus_rd) |-> bus_rdata_r == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_rd_mode; $past(bus_rd && bus_addr == 16'hFFF9) |-> (bus_rdata_r & 8'h67) == 8'h00;
  endproperty
  a_rd_mode: assert property (p_rd_mode) else $error("unused mode bits set");
  property p_stop; stop_mode && $past(stop_mode) |->
    !(interval_irq_r || nmi_req_r || wdt_reset_req_r); endproperty
  a_stop: assert property (p_stop) else $error("overflow while stopped");
  property p_sub; cpu_on_subclock && $past(cpu_on_subclock) |->
    !(interval_irq_r || nmi_req_r || wdt_reset_req_r); endproperty
  a_sub: assert property (p_sub) else $error("overflow on subclock");
  property p_pend; interval_irq_r |-> ##[0:1] wd_pending_flag_r; endproperty
  a_pend: assert property (p_pend) else $error("flag not set by irq");
endmodule : wdit_monitor

//--- tb_top.sv
// Purpose: self-checking bench for the watchdog / interval timer
// Assumes: code 0 gives 2048 clk per overflow at full-rate main clock
// Notes:   any event with no note queued counts as a mismatch
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, resetn = 0, bus_wr = 0, bus_rd = 0, pending_clr = 0, wd_irq_mask = 0;
  logic wd_irq_priority = 0, halt_mode = 0, stop_mode = 0, cpu_on_subclock = 0;
  logic main_clock_halving_sel = 1, rd_pend = 0;
  logic [15:0] bus_addr = 0, a;
  logic [7:0]  bus_wdata = 0, bus_rdata_r, q_rd[$];
  logic [2:0]  q_ev[$];
  logic wd_pending_flag_r, interval_irq_r, interval_irq_prio_r, nmi_req_r, wdt_reset_req_r;
  int n_errors = 0, comparisons = 0, seed = 32'h27da;
  time t_last = 0, t_prev = 0;
  always #50 clk = ~clk;
  wdit_top dut (.*);
  task automatic chk(input logic [15:0] seen, exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic acc(input logic [15:0] ad, input logic [7:0] d, input logic w);
    @(posedge clk) #10;
    bus_addr = ad;
    bus_wdata = d;
    bus_wr = w;
    bus_rd = !w;
    if (!w) q_rd.push_back(d);
    @(posedge clk) #10;
    bus_wr = 0;
    bus_rd = 0;
  endtask : acc
  task automatic wait_ev(input logic [2:0] e, input int n);
    q_ev.push_back(e);
    for (int i = 0; i < n && q_ev.size() != 0; i++) @(posedge clk);
    chk(16'(q_ev.size()), 16'h0000, "event missing");
  endtask : wait_ev
  task automatic results();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  always @(posedge clk) #10 wd_irq_priority = 1'($random(seed));
  always @(negedge clk) begin
    if (rd_pend) chk(bus_rdata_r, q_rd.pop_front(), "read");
    rd_pend = bus_rd;
    if (interval_irq_r | nmi_req_r | wdt_reset_req_r) begin
      t_prev = t_last;
      t_last = $time;
      chk({interval_irq_r, nmi_req_r, wdt_reset_req_r},
          q_ev.size() ? q_ev.pop_front() : 3'b111, "event");
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    #10 resetn = 1;
    halt_mode = 1;
    acc(16'hFFF9, 8'h00, 0);
    acc(16'hFF42, 8'h00, 0);
    a = 16'h1000 | 16'($random(seed) & 12'hFFF);
    acc(a, 8'($random(seed)), 1);
    acc(a, 8'h00, 0);
    acc(16'hFFF9, 8'h80, 1);
    wait_ev(3'b100, 2200);
    wait_ev(3'b100, 2200);
    chk(16'((t_last - t_prev) / 100), 16'd2048, "period");
    chk(wd_pending_flag_r, 1, "flag set");
    @(posedge clk) #10 pending_clr = 1;
    @(posedge clk) #10 pending_clr = 0;
    chk(wd_pending_flag_r, 0, "flag clear");
    wd_irq_mask = 1; // masked overflow still raises the flag
    repeat (2100) @(posedge clk);
    chk(wd_pending_flag_r, 1, "masked flag");
    #10 wd_irq_mask = 0;
    main_clock_halving_sel = 0;
    wait_ev(3'b100, 4200);
    wait_ev(3'b100, 4200);
    chk(16'((t_last - t_prev) / 100), 16'd4096, "half period");
    acc(16'hFFF9, 8'h80, 1);
    main_clock_halving_sel = 1;
    stop_mode = 1;
    repeat (2500) @(posedge clk);
    #10 stop_mode = 0;
    cpu_on_subclock = 1;
    repeat (2500) @(posedge clk);
    #10 cpu_on_subclock = 0;
    acc(16'hFFF9, 8'h90, 1);
    wait_ev(3'b010, 4);
    acc(16'hFFF9, 8'h00, 1);
    acc(16'hFFF9, 8'h90, 0);
    for (int k = 0; k < 3; k++) begin
      acc(16'hFFF9, 8'h80, 1);
      repeat (1500) @(posedge clk);
    end
    wait_ev(3'b010, 2200);
    acc(16'hFFF9, 8'h98, 1);
    wait_ev(3'b001, 2200);
    // reset is the only way out of the sticky watchdog mode
    @(posedge clk) #10 resetn = 0;
    repeat (3) @(posedge clk);
    #10 resetn = 1;
    acc(16'hFFF9, 8'h00, 0);
    acc(16'hFF42, 8'h09, 1);
    acc(16'hFF42, 8'h01, 0);
    acc(16'hFFF9, 8'h80, 1);
    wait_ev(3'b100, 4400);
    wait_ev(3'b100, 4400);
    chk(16'((t_last - t_prev) / 100), 16'h1000, "code 1 period");
    @(posedge clk) #10 pending_clr = 1;
    @(posedge clk) #10 pending_clr = 0;
    chk(16'(wd_pending_flag_r), 16'h0000, "flag before select");
    // flag clear, so selecting the watchdog must raise no request
    acc(16'hFFF9, 8'h90, 1);
    repeat (4) @(posedge clk);
    results();
  end
  initial begin
    #6_000_000;
    n_errors++;
    results();
  end
endmodule : tb_top
bind wdit_top wdit_monitor u_mon (.*);
